// [rtl/uasb_stream.sv]
// Function
// RULE1: Three rotating 180-byte planes, write and drain
// RULE2: One OUT packet fills at most one plane
// RULE3: Stereo 16-bit PCM at 44.1 kHz
// RULE4: Host sends nine 176s then one 180
// RULE5: 8x32 FIFO, request when room reaches threshold
// RULE6: Threshold resets to 0h, loaded before play
// RULE7: Each service moves 64 bits to FIFO; code moves one 32-bit word when the ring empties after the first word
// RULE8: Request enabled from start until transmission ends
// RULE9: Stream stopped and buffer empty ends transmission
// RULE10: Start only when stored planes exceed threshold
// RULE11: Plane count and start threshold are parameters
// RULE12: Play code issues first receive request
// RULE13: Receive done: re-request, maybe start transmission
// RULE14: Volume converted and written to DAC
// RULE15: Mute decoded and written to DAC
// RULE16: Suspend enters low power, resume leaves
// RULE17: Bus state code selects the transition
// RULE18: Per-plane lengths, modulo pointers, never read empty
// RULE19: Packet into full ring is dropped
`timescale 1ns/1ps
`default_nettype none
`include "uasb_params.svh"

module uasb_stream #(
   parameter int PLANES = `UASB_PLANES, // RULE11
   parameter int START_THRESHOLD = `UASB_START_THRESHOLD
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // USB receive bytes
   input wire logic rx_byte_valid,
   output logic rx_byte_ready,
   input wire logic [7:0] rx_byte_data,
   output logic rx_request,
   output logic packet_dropped,
   // Notifications
   input wire uasb_pkg::uasb_event_type stream_event,
   input wire logic rx_done_event,
   input wire uasb_pkg::uasb_event_type volume_event,
   input wire uasb_pkg::uasb_event_type mute_event,
   input wire uasb_pkg::uasb_event_type bus_state_event,
   // Configuration
   input wire logic [2:0] tx_threshold_config,
   // Serial audio port
   output logic tx_word_valid,
   input wire logic tx_word_ready,
   output logic [31:0] tx_word_data,
   output logic tx_fifo_empty_irq,
   // Status
   output logic tx_running,
   output logic low_power,
   output uasb_pkg::uasb_bus_type bus_state,
   // DAC I2C writes
   output logic i2c_valid,
   output uasb_pkg::uasb_i2c_cmd_type i2c_cmd,
   input wire logic i2c_ready
);
   import uasb_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   localparam int PB = `UASB_PLANE_BYTES;
   localparam int PW = (PLANES > 1) ? $clog2(PLANES) : 1;
   localparam int TCW = $clog2(`UASB_TXF_DEPTH + 1);
   localparam logic [7:0] PB8 = 8'(PB);

   typedef struct packed {
      logic [PLANES-1:0][PB-1:0][7:0] plane; // RULE1
      logic [PLANES-1:0][7:0] len;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [7:0] wpos;
      logic [7:0] rpos;
      logic drop;
      logic done_pend;
      logic streaming;
      logic tx_run;
      logic [2:0] thr;
      uasb_bus_type bus;
      logic low_power;
      logic rx_req;
      logic dropped;
      logic lp_enter;
      logic lp_leave;
      uasb_move_type mv;
   } uasb_state_type;

   uasb_state_type q, s;

   logic in_valid, in_pop;
   logic [7:0] in_data;
   logic tx_push, tx_in_ready;
   logic [31:0] tx_word;
   logic [TCW-1:0] tx_count;
   logic [2:0] filled;
   logic wr_en;
   logic play_now, suspend_now, detach_now;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [PW-1:0] next_plane(input logic [PW-1:0] p);
      return (p == PW'(PLANES-1)) ? '0 : PW'(p + 1'b1); // RULE18
   endfunction : next_plane

   // Room of 2*thr words; thr 1h leaves two of eight stages free
   function automatic logic room_ok(input logic [TCW-1:0] cnt,
                                    input logic [2:0] thr);
      logic [4:0] free;
      free = 5'(`UASB_TXF_DEPTH) - 5'(cnt);
      return free >= {1'b0, thr, 1'b0}; // RULE5
   endfunction : room_ok

   always_comb begin
      filled = '0;
      for (int i = 0; i < PLANES; i++) begin
         filled = 3'(filled + 3'(q.len[i] != '0));
      end
   end

   assign play_now = stream_event.valid &&
                     stream_event.data == `UASB_PLAY_CODE;
   assign suspend_now = bus_state_event.valid &&
                        bus_state_event.data == `UASB_STS_SUSPEND;
   assign detach_now = bus_state_event.valid &&
                       bus_state_event.data == `UASB_STS_DETACH;

   // Request only while running; disabled again when transmission ends
   assign tx_fifo_empty_irq = q.tx_run && room_ok(tx_count, q.thr); // RULE8

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [8:0] rnext;
      logic [2:0] after;
      s = q;
      s.rx_req = 1'b0;
      s.dropped = 1'b0;
      s.lp_enter = 1'b0;
      s.lp_leave = 1'b0;
      tx_push = 1'b0;
      tx_word = '0;
      wr_en = 1'b0;
      rnext = {1'b0, q.rpos} + 9'd4;
      after = filled;
      // Bytes are taken only while awake, so a suspend stalls the host
      in_pop = !q.low_power;
      // Packet fill; the first byte decides whether the plane is free
      if (in_valid && in_pop) begin
         if (q.wpos == '0) begin
            s.drop = (q.len[q.wp] != '0); // RULE19
         end
         wr_en = (q.wpos == '0) ? (q.len[q.wp] == '0)
                 : (!q.drop && q.wpos < PB8); // RULE2
         if (wr_en) begin
            s.plane[q.wp][q.wpos] = in_data; // RULE1
         end
         if (q.wpos < PB8) begin
            s.wpos = 8'(q.wpos + 8'd1);
         end
      end
      // Packet close once its bytes have left the input FIFO
      if (q.done_pend && !in_valid) begin
         if (!q.drop && q.wpos != '0) begin
            s.len[q.wp] = q.wpos; // RULE18
            s.wp = next_plane(q.wp);
            after = 3'(filled + 3'd1);
         end else begin
            s.dropped = 1'b1; // RULE19
         end
         s.wpos = '0;
         s.drop = 1'b0;
         s.done_pend = 1'b0;
         s.rx_req = q.streaming; // RULE13
         if (!q.tx_run && after > 3'(START_THRESHOLD)) begin
            s.tx_run = 1'b1; // RULE10
         end
      end
      if (rx_done_event) begin
         s.done_pend = 1'b1;
      end
      // Each service moves two words, stopping at an empty plane
      case (q.mv)
         UASB_MV_IDLE: begin
            if (tx_fifo_empty_irq && q.len[q.rp] != '0) begin
               s.mv = UASB_MV_W0; // RULE7
            end
         end
         UASB_MV_W0, UASB_MV_W1: begin
            if (q.len[q.rp] == '0) begin
               s.mv = UASB_MV_IDLE; // RULE18
            end else if (tx_in_ready) begin
               tx_push = 1'b1;
               for (int k = 0; k < `UASB_WORD_BYTES; k++) begin // RULE3
                  tx_word[8*k +: 8] = q.plane[q.rp][8'(q.rpos + 8'(k))];
               end
               s.rpos = rnext[7:0];
               if (rnext >= {1'b0, q.len[q.rp]}) begin
                  s.len[q.rp] = '0;
                  s.rp = next_plane(q.rp); // RULE1
                  s.rpos = '0;
               end
               s.mv = (q.mv == UASB_MV_W0) ? UASB_MV_W1 : UASB_MV_IDLE;
            end
         end
         default: begin
            s.mv = UASB_MV_IDLE;
         end
      endcase
      // End of stream with nothing left to fetch
      if (q.tx_run && !q.streaming && filled == '0 &&
          q.mv == UASB_MV_IDLE) begin
         s.tx_run = 1'b0; // RULE9
      end
      // Play loads the threshold and asks for the first packet
      if (play_now) begin
         s.streaming = 1'b1;
         s.thr = tx_threshold_config; // RULE6
         s.rx_req = 1'b1; // RULE12
      end else if (stream_event.valid &&
                   stream_event.data == `UASB_STOP_CODE) begin
         s.streaming = 1'b0;
      end
      // Bus state transitions
      if (bus_state_event.valid) begin
         case (bus_state_event.data)
            `UASB_STS_DETACH: begin
               s.bus = UASB_BUS_DETACHED; // RULE17
               s.streaming = 1'b0;
               s.tx_run = 1'b0;
               s.mv = UASB_MV_IDLE;
               s.len = '0;
               s.wp = '0;
               s.rp = '0;
               s.wpos = '0;
               s.rpos = '0;
               s.drop = 1'b0;
               s.done_pend = 1'b0;
               s.low_power = 1'b0;
            end
            `UASB_STS_DEFAULT: begin
               s.bus = UASB_BUS_DEFAULT; // RULE17
            end
            `UASB_STS_ADDRESS: begin
               s.bus = UASB_BUS_ADDRESSED; // RULE17
            end
            `UASB_STS_SUSPEND: begin
               s.bus = UASB_BUS_SUSPENDED; // RULE16
               s.low_power = 1'b1;
               s.lp_enter = 1'b1;
            end
            `UASB_STS_RESUME: begin
               if (q.low_power) begin
                  s.bus = UASB_BUS_ADDRESSED; // RULE16
                  s.low_power = 1'b0;
                  s.lp_leave = 1'b1;
               end
            end
            default: begin
               s.bus = q.bus;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         q <= '0;
         q.thr <= `UASB_THR_RESET; // RULE6
      end else begin
         q <= s;
      end
   end

   assign rx_request = q.rx_req;
   assign packet_dropped = q.dropped;
   assign tx_running = q.tx_run;
   assign low_power = q.low_power;
   assign bus_state = q.bus;

   // ************************************************************
   // Input buffer, transmit FIFO and DAC writes
   // ************************************************************
   uasb_fifo #(.WIDTH(`UASB_INF_WIDTH), .DEPTH(`UASB_INF_DEPTH)) u_in_fifo (
      .clock(clock),
      .rstn(rstn),
      .in_valid(rx_byte_valid),
      .in_ready(rx_byte_ready),
      .in_data(rx_byte_data),
      .out_valid(in_valid),
      .out_ready(in_pop),
      .out_data(in_data),
      .count()
   );

   uasb_fifo #(.WIDTH(`UASB_TXF_WIDTH), .DEPTH(`UASB_TXF_DEPTH)) u_tx_fifo (
      .clock(clock),
      .rstn(rstn),
      .in_valid(tx_push),
      .in_ready(tx_in_ready),
      .in_data(tx_word),
      .out_valid(tx_word_valid),
      .out_ready(tx_word_ready),
      .out_data(tx_word_data),
      .count(tx_count)
   );

   uasb_dac_ctrl u_dac (
      .clock(clock),
      .rstn(rstn),
      .volume_event(volume_event),
      .mute_event(mute_event),
      .lp_enter(q.lp_enter),
      .lp_leave(q.lp_leave),
      .i2c_valid(i2c_valid),
      .i2c_cmd(i2c_cmd),
      .i2c_ready(i2c_ready)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   property p_irq_only_running;
      @(posedge clock) disable iff (!rstn)
      tx_fifo_empty_irq |-> tx_running &&
         (5'(tx_count) + {1'b0, q.thr, 1'b0} <= 5'(`UASB_TXF_DEPTH));
   endproperty
   a_irq_only_running: assert property (p_irq_only_running) // RULE8
      else $error("transmit request while idle or short of room");

   property p_play_request;
      @(posedge clock) disable iff (!rstn)
      play_now |=> rx_request ##1 !rx_request [*1];
   endproperty
   a_play_request: assert property (p_play_request) // RULE12
      else $error("no receive request after play");

   property p_done_request;
      @(posedge clock) disable iff (!rstn)
      (q.done_pend && !in_valid && q.streaming) |=> rx_request;
   endproperty
   a_done_request: assert property (p_done_request) // RULE13
      else $error("no receive request after receive done");

   property p_thr_hold;
      @(posedge clock) disable iff (!rstn)
      !play_now |=> $stable(q.thr);
   endproperty
   a_thr_hold: assert property (p_thr_hold) // RULE6
      else $error("threshold changed outside play");

   property p_two_words;
      @(posedge clock) disable iff (!rstn)
      (q.mv == UASB_MV_W0 && tx_push && !detach_now) |=>
         (q.mv == UASB_MV_W1);
   endproperty
   a_two_words: assert property (p_two_words) // RULE7
      else $error("second word of service skipped");

   property p_stop_end;
      @(posedge clock) disable iff (!rstn)
      (q.tx_run && !q.streaming && filled == '0 &&
       q.mv == UASB_MV_IDLE) |=> !tx_running;
   endproperty
   a_stop_end: assert property (p_stop_end) // RULE9
      else $error("transmission kept after drained stop");

   property p_start_level;
      @(posedge clock) disable iff (!rstn)
      $rose(tx_running) |-> ($past(filled) >= 3'(START_THRESHOLD));
   endproperty
   a_start_level: assert property (p_start_level) // RULE10
      else $error("transmission started too early");

   property p_no_write_full;
      @(posedge clock) disable iff (!rstn)
      wr_en |-> (q.len[q.wp] == '0);
   endproperty
   a_no_write_full: assert property (p_no_write_full) // RULE19
      else $error("write into a stored plane");

   property p_no_read_empty;
      @(posedge clock) disable iff (!rstn)
      tx_push |-> (q.len[q.rp] != '0) && q.tx_run;
   endproperty
   a_no_read_empty: assert property (p_no_read_empty) // RULE18
      else $error("read from an empty plane");

   property p_suspend_lp;
      @(posedge clock) disable iff (!rstn)
      suspend_now |=> low_power && bus_state == UASB_BUS_SUSPENDED;
   endproperty
   a_suspend_lp: assert property (p_suspend_lp) // RULE16
      else $error("suspend did not enter low power");

   c_start: cover property (@(posedge clock) disable iff (!rstn)
      $rose(tx_running));
   c_drop: cover property (@(posedge clock) disable iff (!rstn)
      packet_dropped);
   c_stop: cover property (@(posedge clock) disable iff (!rstn)
      $fell(tx_running));

endmodule : uasb_stream

`default_nettype wire

// [rtl/uasb_params.svh]
`ifndef UASB_PARAMS_SVH
`define UASB_PARAMS_SVH

// ***************************************************************
// Buffer geometry
// ***************************************************************
`define UASB_PLANES 3
`define UASB_PLANE_BYTES 180
`define UASB_START_THRESHOLD 2
`define UASB_WORD_BYTES 4

// ***************************************************************
// FIFOs
// ***************************************************************
`define UASB_TXF_WIDTH 32
`define UASB_TXF_DEPTH 8
`define UASB_THR_RESET 3'h0
`define UASB_INF_WIDTH 8
`define UASB_INF_DEPTH 4

// ***************************************************************
// Event data codes
// ***************************************************************
`define UASB_STOP_CODE 16'h0000
`define UASB_PLAY_CODE 16'h0001
`define UASB_MUTE_OFF 16'h0000
`define UASB_MUTE_ON 16'h0001
`define UASB_STS_DETACH 16'h0000
`define UASB_STS_DEFAULT 16'h0001
`define UASB_STS_ADDRESS 16'h0002
`define UASB_STS_SUSPEND 16'h0003
`define UASB_STS_RESUME 16'h0004

// ***************************************************************
// DAC register map and scale
// ***************************************************************
`define UASB_DAC_REG_VOLUME 8'h01
`define UASB_DAC_REG_MUTE 8'h02
`define UASB_DAC_REG_POWER 8'h03
`define UASB_DAC_MUTE_SET 8'h01
`define UASB_DAC_MUTE_CLR 8'h00
`define UASB_DAC_PWR_LOW 8'h01
`define UASB_DAC_PWR_NORMAL 8'h00
`define UASB_DAC_VOL_MAX 8'h3f

`endif

// [rtl/uasb_pkg.sv]
package uasb_pkg;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } uasb_event_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] value;
   } uasb_i2c_cmd_type;

   // ************************************************************
   // States
   // ************************************************************
   typedef enum logic [2:0] {
      UASB_BUS_DETACHED,
      UASB_BUS_DEFAULT,
      UASB_BUS_ADDRESSED,
      UASB_BUS_SUSPENDED
   } uasb_bus_type;

   typedef enum logic [1:0] {
      UASB_MV_IDLE,
      UASB_MV_W0,
      UASB_MV_W1
   } uasb_move_type;

endpackage : uasb_pkg

// [rtl/uasb_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module uasb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0] count
);
   import uasb_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] cnt;
   } uasb_fifo_state_type;

   uasb_fifo_state_type q, s;
   logic push, pop;

   // Pointers wrap at DEPTH, which need not be a power of two
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
   endfunction : bump

   assign in_ready = (q.cnt != CW'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rd];
   assign count = q.cnt;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next state
   always_comb begin
      s = q;
      if (push) begin
         s.mem[q.wr] = in_data;
         s.wr = bump(q.wr);
      end
      if (pop) begin
         s.rd = bump(q.rd);
      end
      s.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end

   // Refusal only when truly full
   property p_fifo_full_refuse;
      @(posedge clock) disable iff (!rstn)
      (in_valid && !in_ready) |-> (count == CW'(DEPTH));
   endproperty
   a_fifo_full_refuse: assert property (p_fifo_full_refuse) // RULE5
      else $error("fifo refused while not full");

endmodule : uasb_fifo

`default_nettype wire

// [rtl/uasb_dac_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uasb_params.svh"

module uasb_dac_ctrl (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Control requests
   input wire uasb_pkg::uasb_event_type volume_event,
   input wire uasb_pkg::uasb_event_type mute_event,
   input wire logic lp_enter,
   input wire logic lp_leave,
   // I2C write request
   output logic i2c_valid,
   output uasb_pkg::uasb_i2c_cmd_type i2c_cmd,
   input wire logic i2c_ready
);
   import uasb_pkg::*;

   typedef struct packed {
      logic [3:0] pend;
      logic [15:0] vol;
      logic mute;
      logic busy;
      uasb_i2c_cmd_type cmd;
   } uasb_dac_state_type;

   uasb_dac_state_type q, s;

   // Class volume is signed 1/256 dB; DAC takes 1 dB steps below max
   function automatic logic [7:0] vol_scale(input logic [15:0] v);
      logic signed [15:0] db;
      logic signed [15:0] lvl;
      db = $signed(v) >>> 8;
      lvl = 16'($signed({8'h00, `UASB_DAC_VOL_MAX}) + db);
      if (lvl < 0) return 8'h00;
      if (lvl > $signed({8'h00, `UASB_DAC_VOL_MAX}))
         return `UASB_DAC_VOL_MAX;
      return lvl[7:0];
   endfunction : vol_scale

   assign i2c_valid = q.busy;
   assign i2c_cmd = q.cmd;

   // Serve one pending write at a time, power first
   always_comb begin
      s = q;
      if (q.busy && i2c_ready) begin
         s.busy = 1'b0;
      end
      if (!q.busy) begin
         if (q.pend[2]) begin
            s.cmd = '{`UASB_DAC_REG_POWER, `UASB_DAC_PWR_LOW}; // RULE16
            s.pend[2] = 1'b0;
            s.busy = 1'b1;
         end else if (q.pend[3]) begin
            s.cmd = '{`UASB_DAC_REG_POWER, `UASB_DAC_PWR_NORMAL}; // RULE16
            s.pend[3] = 1'b0;
            s.busy = 1'b1;
         end else if (q.pend[0]) begin
            s.cmd = '{`UASB_DAC_REG_VOLUME, vol_scale(q.vol)}; // RULE14
            s.pend[0] = 1'b0;
            s.busy = 1'b1;
         end else if (q.pend[1]) begin
            s.cmd = '{`UASB_DAC_REG_MUTE, q.mute ? `UASB_DAC_MUTE_SET
                      : `UASB_DAC_MUTE_CLR}; // RULE15
            s.pend[1] = 1'b0;
            s.busy = 1'b1;
         end
      end
      // New requests win over the clear above
      if (volume_event.valid) begin
         s.pend[0] = 1'b1;
         s.vol = volume_event.data;
      end
      // Codes other than on or off are ignored
      if (mute_event.valid && (mute_event.data == `UASB_MUTE_ON ||
          mute_event.data == `UASB_MUTE_OFF)) begin
         s.pend[1] = 1'b1;
         s.mute = (mute_event.data == `UASB_MUTE_ON); // RULE15
      end
      if (lp_enter) begin
         s.pend[2] = 1'b1;
         s.pend[3] = 1'b0;
      end
      if (lp_leave) begin
         s.pend[3] = 1'b1;
         s.pend[2] = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end

   property p_vol_write;
      @(posedge clock) disable iff (!rstn)
      (volume_event.valid && !q.busy && q.pend[3:2] == 2'b00 && !lp_enter
       && !lp_leave) |-> ##[1:16]
       (i2c_valid && i2c_cmd.addr == `UASB_DAC_REG_VOLUME);
   endproperty
   a_vol_write: assert property (p_vol_write) // RULE14
      else $error("volume write not issued");

endmodule : uasb_dac_ctrl

`default_nettype wire

// [sim/uasb_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module uasb_far_model #(
   parameter int DELAY = 2
) (
   // Clock
   input wire logic clock,
   // Serial audio port side
   input wire logic pop_en,
   input wire logic tx_word_valid,
   output logic tx_word_ready,
   input wire logic [31:0] tx_word_data,
   output int words,
   output logic [31:0] first_word,
   // DAC I2C engine side
   input wire logic i2c_valid,
   input wire uasb_pkg::uasb_i2c_cmd_type i2c_cmd,
   output logic i2c_ready,
   output uasb_pkg::uasb_i2c_cmd_type last_cmd
);
   import uasb_pkg::*;
   int wait_n = 0;
   // ***************
   // Serial drain
   // ***************
   // Bench stalls the port so that the ring can fill up
   assign tx_word_ready = pop_en;
   // Count words, keep the first for byte order checks
   always @(posedge clock) begin
      if (tx_word_valid && tx_word_ready) begin
         if (words == 0) begin
            first_word <= tx_word_data;
         end
         words <= words + 1;
      end
   end
   // ***************
   // I2C engine
   // ***************
   // Slow on purpose: a DAC write must hold until taken
   always @(posedge clock) begin
      if (i2c_valid && i2c_ready) begin
         last_cmd <= i2c_cmd;
         i2c_ready <= 1'b0;
         wait_n <= 0;
      end else if (i2c_valid) begin
         wait_n <= wait_n + 1;
         i2c_ready <= (wait_n >= DELAY);
      end
   end
   // Idle after power-up
   initial begin
      words = 0;
      first_word = 32'h0;
      i2c_ready = 1'b0;
      last_cmd = '0;
   end
endmodule : uasb_far_model
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uasb_params.svh"
module tb_top;
   import uasb_pkg::*;
   logic clock = 1'b0, rstn = 1'b0, rx_byte_valid = 1'b0, pop_en = 1'b0;
   logic rx_done_event = 1'b0, drop_seen = 1'b0, irq_seen = 1'b0;
   logic [7:0] rx_byte_data = 8'h00;
   logic [2:0] tx_threshold_config = 3'h1;
   uasb_event_type stream_event = '0, volume_event = '0;
   uasb_event_type mute_event = '0, bus_state_event = '0;
   logic rx_byte_ready, rx_request, packet_dropped, tx_word_valid;
   logic tx_word_ready, tx_fifo_empty_irq, tx_running, low_power;
   logic i2c_valid, i2c_ready;
   logic [31:0] tx_word_data, first_word;
   uasb_i2c_cmd_type i2c_cmd, last_cmd;
   uasb_bus_type bus_state;
   int words, num_errors = 0, comparisons = 0;
   int kind [5] = '{1, 1, 1, 2, 2};
   logic [15:0] din [5] = '{16'h0000, 16'hf600, 16'h8000, 16'h0001, 16'h0000};
   logic [15:0] dexp [5] = '{16'h013f, 16'h0135, 16'h0100, 16'h0201, 16'h0200};
   // ***************
   // Design and far side
   // ***************
   uasb_stream #(.PLANES(3), .START_THRESHOLD(2)) DUT (.clock, .rstn,
      .rx_byte_valid, .rx_byte_ready, .rx_byte_data, .rx_request,
      .packet_dropped, .stream_event, .rx_done_event, .volume_event,
      .mute_event, .bus_state_event, .tx_threshold_config, .tx_word_valid,
      .tx_word_ready, .tx_word_data, .tx_fifo_empty_irq, .tx_running,
      .low_power, .bus_state, .i2c_valid, .i2c_cmd, .i2c_ready);
   uasb_far_model #(.DELAY(2)) far (.clock, .pop_en, .tx_word_valid,
      .tx_word_ready, .tx_word_data, .words, .first_word, .i2c_valid,
      .i2c_cmd, .i2c_ready, .last_cmd);
   // Clock of 100 ns
   always #50 clock = ~clock;
   // Pulses may fall between bench samples, so latch them
   always @(posedge clock) begin
      drop_seen <= drop_seen | packet_dropped;
      irq_seen <= irq_seen | tx_fifo_empty_irq;
   end
   // ***************
   // Helpers
   // ***************
   task check(input string name, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task results;
      if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   task tick;
      @(posedge clock);
      #1;
   endtask : tick
   function automatic logic pick(input int s);
      case (s)
         0: return rx_request;
         1: return tx_running;
         2: return i2c_valid;
         3: return low_power;
         default: return rx_byte_ready;
      endcase
   endfunction : pick
   // Bounded wait; running out ends the run
   task wait_on(input int s, input logic v, input int n);
      for (int i = 0; i < n && pick(s) !== v; i++) tick();
      if (pick(s) !== v) begin
         check("wait", 0, 1);
         results();
      end
   endtask : wait_on
   task ev(input int k, input logic [15:0] d);
      uasb_event_type e;
      e = '{valid: 1'b1, data: d};
      case (k)
         0: stream_event = e;
         1: volume_event = e;
         2: mute_event = e;
         default: bus_state_event = e;
      endcase
      tick();
      {stream_event, volume_event, mute_event, bus_state_event} = '0;
   endtask : ev
   // One OUT packet of n bytes, valued by index
   task send(input int n);
      for (int i = 0; i < n; i++) begin
         rx_byte_valid = 1'b1;
         rx_byte_data = i[7:0];
         wait_on(5, 1'b1, 50);
         tick();
      end
      rx_byte_valid = 1'b0;
      rx_done_event = 1'b1;
      tick();
      rx_done_event = 1'b0;
      wait_on(0, 1'b1, 20);
   endtask : send
   task dac(input logic [15:0] exp);
      wait_on(2, 1'b1, 4);
      wait_on(2, 1'b0, 20);
      check("i2c_cmd", last_cmd, exp);
   endtask : dac
   // ***************
   // Main sequence
   // ***************
   initial begin
      repeat (4) @(posedge clock);
      #1 rstn = 1'b1;
      check("bus_state", bus_state, UASB_BUS_DETACHED);
      ev(0, `UASB_PLAY_CODE);
      wait_on(0, 1'b1, 4);
      send(176);
      send(176);
      check("running", tx_running, 0);
      check("irq", tx_fifo_empty_irq, 0);
      send(180);
      wait_on(1, 1'b1, 10);
      send(176);
      tick();
      check("dropped", drop_seen, 1);
      check("irq_full", tx_fifo_empty_irq, 0);
      check("irq_seen", irq_seen, 1);
      ev(0, `UASB_STOP_CODE);
      pop_en = 1'b1;
      wait_on(1, 1'b0, 2000);
      check("irq_off", tx_fifo_empty_irq, 0);
      repeat (20) tick();
      check("words", words, 133);
      check("first_word", first_word, 32'h03020100);
      for (int i = 0; i < 5; i++) begin
         ev(kind[i], din[i]);
         dac(dexp[i]);
      end
      ev(3, `UASB_STS_SUSPEND);
      wait_on(3, 1'b1, 2);
      check("suspended", bus_state, UASB_BUS_SUSPENDED);
      repeat (4) begin
         rx_byte_valid = 1'b1;
         tick();
      end
      rx_byte_valid = 1'b0;
      check("rx_ready", rx_byte_ready, 0);
      dac({`UASB_DAC_REG_POWER, `UASB_DAC_PWR_LOW});
      ev(3, `UASB_STS_RESUME);
      wait_on(3, 1'b0, 2);
      dac({`UASB_DAC_REG_POWER, `UASB_DAC_PWR_NORMAL});
      for (int i = 1; i < 4; i++) begin
         ev(3, 16'(i % 3));
         tick();
         check("bus_state", bus_state, i % 3);
      end
      results();
   end
endmodule : tb_top
`default_nettype wire
